// >>> rtl/dcef_fifo.sv
// dual clock embedded fifo controller with an axi4-lite register slave
`timescale 1ns/1ps
`default_nettype none
module dcef_fifo #(
  parameter int DATA_W = 36,
  parameter int NUM_BLOCKS = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic wclk_i,
  input wire logic wen_i,
  input wire logic [DATA_W-1:0] write_word_in_i,
  input wire logic rclk_i,
  input wire logic ren_i,
  output logic [DATA_W-1:0] read_word_o,
  output logic full_o,
  output logic empty_o,
  output logic near_full_flag_o,
  output logic near_empty_flag_o,
  output logic irq_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // entries per block follow the shape chosen
  function automatic int block_depth(input int w);
    block_depth = (w >= dcef_pkg::WIDE_MIN_W) ? dcef_pkg::BLOCK_BITS_WIDE / w
                                              : dcef_pkg::BLOCK_BITS_NARROW / w;
  endfunction
  // total depth scales with blocks combined
  localparam int DEPTH = NUM_BLOCKS * block_depth(DATA_W);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_CNT = (AW + 1)'(DEPTH);
  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction
  function automatic logic [AW:0] gray2bin(input logic [AW:0] g);
    logic [AW:0] b;
    b = g;
    for (int i = AW - 1; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction
  // strobe lanes merged into a word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction
  // pin synchronisers, data delayed alongside its strobes
  logic [DATA_W+1:0] wpin_s1, wpin_s2;
  logic [1:0] rpin_s1, rpin_s2;
  logic wclk_d, rclk_d;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wpin_s1 <= '0;
      wpin_s2 <= '0;
      rpin_s1 <= '0;
      rpin_s2 <= '0;
      wclk_d <= 1'b0;
      rclk_d <= 1'b0;
    end else begin
      wpin_s1 <= {wclk_i, wen_i, write_word_in_i};
      wpin_s2 <= wpin_s1;
      rpin_s1 <= {rclk_i, ren_i};
      rpin_s2 <= rpin_s1;
      wclk_d <= wpin_s2[DATA_W+1];
      rclk_d <= rpin_s2[1];
    end
  end
  // each port acts only on its own clock edge
  logic wr_edge, rd_edge, wr_req, rd_req, wr_do, rd_do;
  assign wr_edge = wpin_s2[DATA_W+1] & ~wclk_d;
  assign rd_edge = rpin_s2[1] & ~rclk_d;
  assign wr_req = wr_edge & wpin_s2[DATA_W];
  assign rd_req = rd_edge & rpin_s2[0];
  assign wr_do = wr_req & ~full_o;
  assign rd_do = rd_req & ~empty_o;
  logic flush;
  logic [AW:0] wbin, rbin, wgray, rgray;
  logic [AW:0] rgray_s1, rgray_s2, wgray_s1, wgray_s2;
  logic [DATA_W-1:0] mem [DEPTH];
  // write pointer kept binary and gray, one gray bit per step
  // pointer moves only on an accepted write
  // reset and flush empty the fifo
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wbin <= '0;
      wgray <= '0;
    end else if (flush) begin
      wbin <= '0;
      wgray <= '0;
    end else if (wr_do) begin
      wbin <= wbin + 1'b1;
      wgray <= bin2gray(wbin + 1'b1);
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rbin <= '0;
      rgray <= '0;
    end else if (flush) begin
      rbin <= '0;
      rgray <= '0;
    end else if (rd_do) begin
      rbin <= rbin + 1'b1;
      rgray <= bin2gray(rbin + 1'b1);
    end
  end
  // gray pointers cross through two stages, flush clears them
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rgray_s1 <= '0;
      rgray_s2 <= '0;
      wgray_s1 <= '0;
      wgray_s2 <= '0;
    end else begin
      rgray_s1 <= flush ? '0 : rgray;
      rgray_s2 <= flush ? '0 : rgray_s1;
      wgray_s1 <= flush ? '0 : wgray;
      wgray_s2 <= flush ? '0 : wgray_s1;
    end
  end
  // store the presented word on an accepted write
  always_ff @(posedge clk_sys_i) begin
    if (wr_do) begin
      mem[wbin[AW-1:0]] <= wpin_s2[DATA_W-1:0];
    end
  end
  // oldest word driven out on an accepted read
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      read_word_o <= '0;
    end else if (rd_do) begin
      read_word_o <= mem[rbin[AW-1:0]];
    end
  end
  // fill levels, each seen from its own side
  logic [AW:0] wr_level, rd_level, next_wbin, next_rbin;
  logic [15:0] full_thresh, empty_thresh;
  assign next_wbin = wr_do ? wbin + 1'b1 : wbin;
  assign next_rbin = rd_do ? rbin + 1'b1 : rbin;
  assign wr_level = next_wbin - gray2bin(rgray_s2);
  assign rd_level = gray2bin(wgray_s2) - next_rbin;

  // near-full from write side level, near-empty from read side
  // empty flags set and full flags clear at reset
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      full_o <= 1'b0;
      near_full_flag_o <= 1'b0;
      empty_o <= 1'b1;
      near_empty_flag_o <= 1'b1;
    end else if (flush) begin
      full_o <= 1'b0;
      near_full_flag_o <= 1'b0;
      empty_o <= 1'b1;
      near_empty_flag_o <= 1'b1;
    end else begin
      full_o <= (wr_level == DEPTH_CNT);
      near_full_flag_o <= (16'(wr_level) >= full_thresh);
      empty_o <= (rd_level == '0);
      near_empty_flag_o <= (16'(rd_level) <= empty_thresh);
    end
  end

  // interrupt events and their edges
  logic nf_d, ne_d;
  logic [dcef_pkg::IRQ_W-1:0] irq_stat, irq_mask, irq_evt;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      nf_d <= 1'b0;
      ne_d <= 1'b1;
    end else begin
      nf_d <= near_full_flag_o;
      ne_d <= near_empty_flag_o;
    end
  end
  // refused accesses are reported as events only
  always_comb begin
    irq_evt = '0;
    irq_evt[dcef_pkg::IRQ_OVERFLOW_BIT] = wr_req & full_o;
    irq_evt[dcef_pkg::IRQ_UNDERFLOW_BIT] = rd_req & empty_o;
    irq_evt[dcef_pkg::IRQ_NEAR_FULL_BIT] = near_full_flag_o & ~nf_d;
    irq_evt[dcef_pkg::IRQ_NEAR_EMPTY_BIT] = near_empty_flag_o & ~ne_d;
  end
  assign irq_o = |(irq_stat & irq_mask);

  // axi4-lite write side
  logic aw_got, w_got, rd_irq_clr;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_wr;
  assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
  assign s_axi_wready = ~w_got & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr = aw_got & w_got & ~s_axi_bvalid;
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcef_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          dcef_pkg::CTRL_OFS, dcef_pkg::FULL_THRESH_OFS, dcef_pkg::EMPTY_THRESH_OFS,
          dcef_pkg::IRQ_MASK_OFS, dcef_pkg::STATUS_OFS, dcef_pkg::LEVEL_OFS,
          dcef_pkg::IRQ_STAT_OFS: s_axi_bresp <= dcef_pkg::RESP_OKAY;
          default: s_axi_bresp <= dcef_pkg::RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // writable registers; flush is a one-cycle pulse
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flush <= 1'b0;
      full_thresh <= dcef_pkg::FULL_THRESH_RST;
      empty_thresh <= dcef_pkg::EMPTY_THRESH_RST;
      irq_mask <= dcef_pkg::IRQ_MASK_RST;
    end else begin
      flush <= do_wr & (aw_addr == dcef_pkg::CTRL_OFS) & w_strb[0]
               & w_data[dcef_pkg::CTRL_FLUSH_BIT];
      if (do_wr & (aw_addr == dcef_pkg::FULL_THRESH_OFS)) begin
        full_thresh <= 16'(merge({16'h0000, full_thresh}, w_data, w_strb));
      end
      if (do_wr & (aw_addr == dcef_pkg::EMPTY_THRESH_OFS)) begin
        empty_thresh <= 16'(merge({16'h0000, empty_thresh}, w_data, w_strb));
      end
      if (do_wr & (aw_addr == dcef_pkg::IRQ_MASK_OFS) & w_strb[0]) begin
        irq_mask <= w_data[dcef_pkg::IRQ_W-1:0];
      end
    end
  end
  // sticky status, cleared by a read, a new event wins over the clear
  assign rd_irq_clr = s_axi_arvalid & s_axi_arready & (s_axi_araddr == dcef_pkg::IRQ_STAT_OFS);
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat <= '0;
    end else begin
      irq_stat <= (rd_irq_clr ? '0 : irq_stat) | irq_evt;
    end
  end
  // axi4-lite read side, answer one cycle after the address
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= dcef_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= dcef_pkg::RESP_OKAY;
      s_axi_rdata <= '0;
      case (s_axi_araddr)
        dcef_pkg::CTRL_OFS: s_axi_rdata <= '0;
        dcef_pkg::STATUS_OFS: begin
          s_axi_rdata[dcef_pkg::ST_EMPTY_BIT] <= empty_o;
          s_axi_rdata[dcef_pkg::ST_FULL_BIT] <= full_o;
          s_axi_rdata[dcef_pkg::ST_NEAR_EMPTY_BIT] <= near_empty_flag_o;
          s_axi_rdata[dcef_pkg::ST_NEAR_FULL_BIT] <= near_full_flag_o;
        end
        dcef_pkg::LEVEL_OFS: begin
          s_axi_rdata[dcef_pkg::LEVEL_RD_LSB +: 16] <= 16'(rd_level);
          s_axi_rdata[dcef_pkg::LEVEL_WR_LSB +: 16] <= 16'(wr_level);
        end
        dcef_pkg::FULL_THRESH_OFS: s_axi_rdata <= {16'h0000, full_thresh};
        dcef_pkg::EMPTY_THRESH_OFS: s_axi_rdata <= {16'h0000, empty_thresh};
        dcef_pkg::IRQ_STAT_OFS: s_axi_rdata <= 32'(irq_stat);
        dcef_pkg::IRQ_MASK_OFS: s_axi_rdata <= 32'(irq_mask);
        default: s_axi_rresp <= dcef_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/dcef_pkg.sv
// constants shared by the dual clock embedded fifo controller
package dcef_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] LEVEL_OFS = 8'h08;
  localparam logic [7:0] FULL_THRESH_OFS = 8'h0C;
  localparam logic [7:0] EMPTY_THRESH_OFS = 8'h10;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
  // control field positions
  localparam int CTRL_FLUSH_BIT = 0;
  // status field positions
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_NEAR_EMPTY_BIT = 2;
  localparam int ST_NEAR_FULL_BIT = 3;
  // level register halves
  localparam int LEVEL_RD_LSB = 0;
  localparam int LEVEL_WR_LSB = 16;
  // interrupt event bit positions
  localparam int IRQ_OVERFLOW_BIT = 0;
  localparam int IRQ_UNDERFLOW_BIT = 1;
  localparam int IRQ_NEAR_FULL_BIT = 2;
  localparam int IRQ_NEAR_EMPTY_BIT = 3;
  localparam int IRQ_W = 4;
  // reset values
  localparam logic [15:0] FULL_THRESH_RST = 16'h0070;
  localparam logic [15:0] EMPTY_THRESH_RST = 16'h0010;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // memory block geometry
  localparam int BLOCK_BITS_NARROW = 4096;
  localparam int BLOCK_BITS_WIDE = 4608;
  localparam int WIDE_MIN_W = 9;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> test/dcef_fifo_assertions.sv
// concurrent checks on the fifo controller ports
`timescale 1ns/1ps
`default_nettype none
module dcef_fifo_checker #(
  parameter int DATA_W = 36
) (
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  input wire logic full_o,
  input wire logic empty_o,
  input wire logic near_full_flag_o,
  input wire logic near_empty_flag_o,
  input wire logic [DATA_W-1:0] read_word_o,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_full_empty: assert property (!(full_o && empty_o))
    else $error("full and empty together");
  a_reset_flags: assert property ($rose(rst_b_i) |-> empty_o && near_empty_flag_o
    && !full_o && !near_full_flag_o) else $error("flags wrong after reset");
  a_full_near: assert property (full_o |-> near_full_flag_o)
    else $error("full without near full");
  a_empty_near: assert property (empty_o |-> near_empty_flag_o)
    else $error("empty without near empty");
  a_empty_word: assert property (empty_o && $past(empty_o) |=> $stable(read_word_o))
    else $error("read word moved while empty");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind dcef_fifo dcef_fifo_checker #(.DATA_W(DATA_W)) u_dcef_fifo_checker (.*);
`default_nettype wire

// >>> test/dcef_user_model.sv
// fabric user logic on both fifo ports, with link clocks that idle low
`timescale 1ns/1ps
`default_nettype none
module dcef_user_model #(
  parameter int W = 36
) (
  output logic wclk_o,
  output logic wen_o,
  output logic [W-1:0] word_o,
  output logic rclk_o,
  output logic ren_o
);
  // idle levels, data not yet valid shows all ones
  initial begin
    wclk_o = 1'b0;
    wen_o = 1'b0;
    word_o = '1;
    rclk_o = 1'b0;
    ren_o = 1'b0;
  end
  task push(input logic [W-1:0] d);
    #7;
    wen_o = 1'b1;
    word_o = d;
    #100 wclk_o = 1'b1;
    #100 wclk_o = 1'b0;
    wen_o = 1'b0;
    word_o = ~d; // stale data inverted once released
  endtask
  task pop();
    #7;
    ren_o = 1'b1;
    #100 rclk_o = 1'b1;
    #100 rclk_o = 1'b0;
    ren_o = 1'b0;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> test/dual_clock_embedded_fifo_bench.sv
// self-checking bench for the fifo controller
`timescale 1ns/1ps
`default_nettype none
module dual_clock_embedded_fifo_bench;
  localparam int DEPTH = dcef_pkg::BLOCK_BITS_WIDE / 36;
  localparam logic [7:0] RO [6] = '{dcef_pkg::STATUS_OFS, dcef_pkg::LEVEL_OFS,
    dcef_pkg::FULL_THRESH_OFS, dcef_pkg::EMPTY_THRESH_OFS, dcef_pkg::IRQ_MASK_OFS, 8'h1C};
  localparam logic [31:0] RV [6] = '{32'h5, 32'h0, 32'h70, 32'h10, 32'h0, 32'h0};
  localparam logic [1:0] RR [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
  logic clk_sys_i, rst_b_i, wclk_i, wen_i, rclk_i, ren_i;
  logic full_o, empty_o, near_full_flag_o, near_empty_flag_o, irq_o;
  logic [35:0] write_word_in_i, read_word_o;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int bad_count, total_checks, cyc;
  dcef_fifo u_dcef_fifo (.*);
  dcef_user_model #(.W(36)) u_dcef_user_model (.wclk_o(wclk_i), .wen_o(wen_i),
    .word_o(write_word_in_i), .rclk_o(rclk_i), .ren_o(ren_i));
  // system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  // hang guard
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      test_done();
    end
  end
  task chk(input string n, input logic [35:0] s, input logic [35:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task settle();
    repeat (10) @(posedge clk_sys_i);
  endtask
  // bus write, both channels offered together
  task axw(input logic [7:0] a, input logic [31:0] d);
    logic dn;
    dn = 1'b0;
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn) begin
      @(posedge clk_sys_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) dn = 1'b1;
    end
    chk("bresp", s_axi_bresp, 2'h0);
    s_axi_bready <= 1'b0;
  endtask
  task axr(input logic [7:0] a);
    logic dn;
    dn = 1'b0;
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn) begin
      @(posedge clk_sys_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) dn = 1'b1;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task t_reset();
    chk("flags", {full_o, empty_o, near_full_flag_o, near_empty_flag_o, irq_o}, 5'h0A);
    chk("word", read_word_o, 36'h0);
    for (int i = 0; i < 6; i++) begin
      axr(RO[i]);
      chk("reg", rv, RV[i]);
      chk("resp", rs, RR[i]);
    end
    $display("t_reset done");
  endtask
  task t_order();
    axw(dcef_pkg::IRQ_MASK_OFS, 32'h3);
    u_dcef_user_model.pop();
    settle();
    chk("irq", irq_o, 1'b1);
    chk("word", read_word_o, 36'h0);
    axr(dcef_pkg::IRQ_STAT_OFS);
    chk("stat", rv, 32'h2);
    axr(dcef_pkg::IRQ_STAT_OFS);
    chk("stat", rv, 32'h0);
    chk("irq", irq_o, 1'b0);
    for (int i = 0; i < 3; i++) u_dcef_user_model.push({4'hA, 32'(i)});
    settle();
    chk("empty", empty_o, 1'b0);
    for (int i = 0; i < 3; i++) begin
      u_dcef_user_model.pop();
      chk("word", read_word_o, {4'hA, 32'(i)});
    end
    $display("t_order done");
  endtask
  task t_full();
    for (int i = 0; i < DEPTH; i++) u_dcef_user_model.push({4'h5, 32'(i)});
    settle();
    chk("full", {full_o, near_full_flag_o}, 2'h3);
    u_dcef_user_model.push(36'hF_FFFF_FFFF);
    settle();
    chk("irq", irq_o, 1'b1);
    axr(dcef_pkg::LEVEL_OFS);
    chk("level", rv, {16'(DEPTH), 16'(DEPTH)});
    for (int i = 0; i < DEPTH; i++) begin
      u_dcef_user_model.pop();
      chk("word", read_word_o, {4'h5, 32'(i)});
    end
    settle();
    chk("drained", {full_o, empty_o, near_full_flag_o}, 3'h2);
    axr(dcef_pkg::IRQ_STAT_OFS);
    chk("stat", rv, 32'hD);
    $display("t_full done");
  endtask
  task t_thresh();
    axw(dcef_pkg::FULL_THRESH_OFS, 32'h3);
    axw(dcef_pkg::EMPTY_THRESH_OFS, 32'h1);
    u_dcef_user_model.push(36'h1);
    u_dcef_user_model.push(36'h2);
    settle();
    chk("near", {near_full_flag_o, near_empty_flag_o}, 2'h0);
    u_dcef_user_model.push(36'h3);
    u_dcef_user_model.pop();
    u_dcef_user_model.pop();
    settle();
    chk("near", {near_full_flag_o, near_empty_flag_o}, 2'h1);
    axr(dcef_pkg::IRQ_STAT_OFS);
    chk("stat", rv, 32'hC);
    axw(dcef_pkg::CTRL_OFS, 32'h1);
    settle();
    chk("flush", {full_o, empty_o, near_empty_flag_o}, 3'h3);
    axr(dcef_pkg::IRQ_STAT_OFS);
    chk("stat", rv, 32'h0);
    $display("t_thresh done");
  endtask
  task t_rst2();
    u_dcef_user_model.push(36'h7);
    u_dcef_user_model.pop();
    u_dcef_user_model.push(36'h8);
    settle();
    chk("word", read_word_o, 36'h7);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("flags", {full_o, empty_o, near_full_flag_o, near_empty_flag_o, irq_o}, 5'h0A);
    chk("word", read_word_o, 36'h0);
    axr(dcef_pkg::LEVEL_OFS);
    chk("level", rv, 32'h0);
    axr(dcef_pkg::FULL_THRESH_OFS);
    chk("thresh", rv, 32'(dcef_pkg::FULL_THRESH_RST));
    u_dcef_user_model.push(36'h9);
    u_dcef_user_model.pop();
    chk("word", read_word_o, 36'h9);
    $display("t_rst2 done");
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    {rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    total_checks = 0;
    cyc = 0;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    t_reset();
    t_order();
    t_full();
    t_thresh();
    t_rst2();
    test_done();
  end
endmodule
`default_nettype wire
